// ==== design/eeprom_consts.vh ====
// Constants for the serial EEPROM command and protection logic.
// Assumes a single 125 MHz ref_clk and that the serial link is sampled by it.
// Functional notes
// - Chip select low selects the device and keeps it in active power.
// - Chip select high deselects; standby only once no write cycle runs.
// - Hold floats output, ignores input and clock, keeps bit position.
// - Hold starts when hold input falls while serial clock is low.
// - Hold ends when hold input rises while serial clock is low.
// - Chip select rising during hold resets protocol state, abandons work.
// - Writes and status writes execute only on whole multiples of eight clocks.
// - Every modifying instruction needs the write-enable latch set first.
// - Latch clears on reset, write-disable, status write or write completion.
// - Block protect bits are non-volatile; covered addresses are read-only. Here reset reloads the bits with 0.
// - Protect codes: none, from 0600h, from 0400h, whole array.
// - Hardware protected mode makes status-write-disable and protect bits read-only.
// - Execute only if chip select rises after last bit, before next edge.
// - Last bit is opcode or data byte end; not checked for reads.
// - Opcodes: set enable 06h, clear enable 04h, status read 05h.
// - Opcodes: status write 01h, array read 03h, array write 02h.
// - Unknown opcode deselects the device until chip select falls again.
// - Only the set-enable instruction sets the write-enable latch.
// - Set-enable waits for chip select to rise before acting.
// - All bytes shift in and out most significant bit first.
// - Input sampled on rising clock; output changes after falling clock.
// - Hardware protected mode when status-write-disable is one and protect pin low.
// - Write-busy flag reads one while a write cycle runs.
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

`define SYNC_W 5
`define CLK_PERIOD_NS 8
`define WRITE_TIME_NS 5000
`define BUSY_CNT_W 10

`define OPC_SET_WE 8'h06
`define OPC_CLR_WE 8'h04
`define OPC_STAT_RD 8'h05
`define OPC_STAT_WR 8'h01
`define OPC_ARR_RD 8'h03
`define OPC_ARR_WR 8'h02

`define SR_BUSY 0
`define SR_WEL 1
`define SR_BP_LO 2
`define SR_BP_HI 3
`define SR_SWD 7

`define NV_SWD_RST 1'b0
`define NV_BP_RST 2'h0

`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2
`define QUARTER_BASE 11'h600
`define HALF_BASE 11'h400

`define ADDR_BYTES 3'h2
`define ARR_WR_MIN 3'h4
`define STAT_WR_LEN 3'h2
`define OPC_LEN 3'h1
`define BYTE_LAST 3'h7
`define ARR_DATA_IDX 3'h3

`endif

// ==== design/pin_sync.v ====
// Two-stage synchroniser for the serial pins.
// Assumes the pins are asynchronous to ref_clk; the first stage feeds only the second.
module pin_sync (
  input wire ref_clk,
  input wire rst_n,
  input wire [4:0] pin_in,
  output reg [4:0] pin_out
);
`include "eeprom_consts.vh"

  reg [4:0] meta_q;

  // Idle pins settle high so no false select appears at reset release
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_q <= 5'h1F;
      pin_out <= 5'h1F;
    end else begin
      meta_q <= pin_in;
      pin_out <= meta_q;
    end
  end

endmodule

// ==== design/eeprom_cmd_protect.v ====
// Serial EEPROM command decoder, status register and protection logic.
// Assumes an array memory outside answers mem_rdata in the cycle after mem_addr.
// The serial clock is sampled by ref_clk, so it must run well below ref_clk / 4.
`include "eeprom_consts.vh"
module eeprom_cmd_protect #(
  parameter WRITE_TIME_NS = `WRITE_TIME_NS
) (
  input wire ref_clk,
  input wire rst_n,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire spi_hold_n,
  input wire spi_wp_n,
  output reg spi_miso,
  output wire spi_miso_oe,
  output reg [10:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  input wire [7:0] mem_rdata,
  output wire active_pwr,
  output wire standby_pwr,
  output wire hold_state,
  output wire [7:0] status_protect_register
);

  localparam integer WR_CYC_I = (WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  // Busy counter is ten bits wide, so write times above about 8 us do not fit
  localparam [9:0] WR_CYC = WR_CYC_I[9:0];

  localparam [2:0] ST_OPC = 3'h0;
  localparam [2:0] ST_ADR = 3'h1;
  localparam [2:0] ST_DAT = 3'h2;
  localparam [2:0] ST_RDO = 3'h3;
  localparam [2:0] ST_WAIT = 3'h4;

  wire [4:0] pins_s;
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  wire hold_n_s;
  wire wp_n_s;

  reg sclk_d_q;
  reg cs_n_d_q;
  reg armed_q;
  reg ignore_q;
  reg hold_q;
  reg [2:0] state_q;
  reg [2:0] bit_cnt_q;
  reg [2:0] byte_cnt_q;
  reg [7:0] rx_q;
  reg [7:0] opc_q;
  reg [15:0] adr_q;
  reg [7:0] wdata_q;
  reg [7:0] tx_q;
  reg load_pend_q;
  reg wel_q;
  reg busy_q;
  reg [9:0] busy_cnt_q;
  reg busy_is_sr_q;
  reg swd_q;
  reg [1:0] bp_q;
  reg swd_pend_q;
  reg [1:0] bp_pend_q;

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in({spi_wp_n, spi_hold_n, spi_mosi, spi_cs_n, spi_sclk}),
    .pin_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign mosi_s = pins_s[2];
  assign hold_n_s = pins_s[3];
  assign wp_n_s = pins_s[4];

  wire cs_fall = cs_n_d_q & ~cs_n_s;
  wire cs_rise = ~cs_n_d_q & cs_n_s;
  wire sel = armed_q & ~cs_n_s & ~ignore_q;
  wire sclk_rise = sel & ~hold_q & sclk_s & ~sclk_d_q;
  wire sclk_fall = sel & ~hold_q & ~sclk_s & sclk_d_q;
  wire [7:0] rx_n = {rx_q[6:0], mosi_s};
  wire byte_done = sclk_rise & (bit_cnt_q == `BYTE_LAST);

  wire hw_prot = swd_q & ~wp_n_s;

  assign status_protect_register = {swd_q, 3'h0, bp_q, wel_q, busy_q};

  assign active_pwr = ~cs_n_s;
  assign standby_pwr = cs_n_s & ~busy_q;
  assign hold_state = hold_q;

  assign spi_miso_oe = sel & ~hold_q & (state_q == ST_RDO);

  reg addr_prot;
  always @* begin
    case (bp_q)
      `BP_NONE: addr_prot = 1'b0;
      `BP_QUARTER: addr_prot = (adr_q[10:0] >= `QUARTER_BASE);
      `BP_HALF: addr_prot = (adr_q[10:0] >= `HALF_BASE);
      default: addr_prot = 1'b1;
    endcase
  end

  // Instructions that are checked at deselect, with their byte lengths
  wire end_ok = armed_q & ~ignore_q & ~hold_q & ~busy_q & (bit_cnt_q == 3'h0);
  wire do_set_we = cs_rise & end_ok & (opc_q == `OPC_SET_WE) & (byte_cnt_q == `OPC_LEN);
  wire do_clr_we = cs_rise & end_ok & (opc_q == `OPC_CLR_WE) & (byte_cnt_q == `OPC_LEN);
  wire do_stat_wr = cs_rise & end_ok & (opc_q == `OPC_STAT_WR) &
                    (byte_cnt_q == `STAT_WR_LEN) & wel_q & ~hw_prot;
  wire do_arr_wr = cs_rise & end_ok & (opc_q == `OPC_ARR_WR) &
                   (byte_cnt_q >= `ARR_WR_MIN) & wel_q & ~addr_prot;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_d_q <= 1'b0;
      cs_n_d_q <= 1'b1;
    end else begin
      sclk_d_q <= sclk_s;
      cs_n_d_q <= cs_n_s;
    end
  end

  // Power-up needs a falling select edge before any instruction
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      ignore_q <= 1'b0;
    end else if (cs_fall) begin
      armed_q <= 1'b1;
      ignore_q <= 1'b0;
    end else if (byte_done && state_q == ST_OPC && !busy_q) begin
      case (rx_n)
        `OPC_SET_WE, `OPC_CLR_WE, `OPC_STAT_RD,
        `OPC_STAT_WR, `OPC_ARR_RD, `OPC_ARR_WR: ignore_q <= ignore_q;
        default: ignore_q <= 1'b1;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
    end else if (cs_n_s) begin
      hold_q <= 1'b0;
    end else if (!sclk_s) begin
      hold_q <= ~hold_n_s;
    end
  end

  // Serial receive framing and opcode decode
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_OPC;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      rx_q <= 8'h00;
      opc_q <= 8'h00;
      adr_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else if (cs_fall || cs_rise) begin
      state_q <= ST_OPC;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      if (cs_fall) begin
        opc_q <= 8'h00;
      end
    end else if (sclk_rise) begin
      rx_q <= rx_n;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (state_q == ST_ADR) begin
        adr_q <= {adr_q[14:0], mosi_s};
      end
      if (byte_done) begin
        if (byte_cnt_q != `BYTE_LAST) begin
          byte_cnt_q <= byte_cnt_q + 3'h1;
        end
        case (state_q)
          ST_OPC: begin
            opc_q <= rx_n;
            // second opcode group
            // While a cycle runs only the status read is served
            if (busy_q && rx_n != `OPC_STAT_RD) begin
              state_q <= ST_WAIT;
            end else begin
              case (rx_n)
                `OPC_SET_WE, `OPC_CLR_WE: state_q <= ST_WAIT;
                `OPC_STAT_RD: state_q <= ST_RDO;
                `OPC_STAT_WR: state_q <= ST_DAT;
                `OPC_ARR_RD, `OPC_ARR_WR: state_q <= ST_ADR;
                default: state_q <= ST_OPC;
              endcase
            end
          end
          ST_ADR: begin
            if (byte_cnt_q == `ADDR_BYTES) begin
              state_q <= (opc_q == `OPC_ARR_RD) ? ST_RDO : ST_DAT;
            end
          end
          ST_DAT: begin
            // Only the first data byte is kept; a page buffer is not built
            if ((opc_q == `OPC_STAT_WR && byte_cnt_q == `OPC_LEN) ||
                (opc_q == `OPC_ARR_WR && byte_cnt_q == `ARR_DATA_IDX)) begin
              wdata_q <= rx_n;
            end
          end
          ST_RDO: state_q <= ST_RDO;
          ST_WAIT: state_q <= ST_WAIT;
          default: state_q <= ST_OPC;
        endcase
      end
    end
  end

  // Read-out path; reads are never checked at deselect
  // reads skip end check
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
      spi_miso <= 1'b0;
      load_pend_q <= 1'b0;
      mem_addr <= 11'h000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      if (cs_fall || cs_rise) begin
        load_pend_q <= 1'b0;
      end else if (byte_done && ((state_q == ST_OPC && rx_n == `OPC_STAT_RD) ||
                   (state_q == ST_RDO && opc_q == `OPC_STAT_RD))) begin
        tx_q <= status_protect_register;
      end else if (byte_done && state_q == ST_ADR && byte_cnt_q == `ADDR_BYTES &&
                   opc_q == `OPC_ARR_RD) begin
        mem_addr <= {adr_q[9:0], mosi_s};
        load_pend_q <= 1'b1;
      end else if (byte_done && state_q == ST_RDO) begin
        load_pend_q <= 1'b1;
      end else if (load_pend_q) begin
        // Data arrives a cycle after the address, then the address steps on
        tx_q <= mem_rdata;
        mem_addr <= mem_addr + 11'h001;
        load_pend_q <= 1'b0;
      end else if (sclk_fall && state_q == ST_RDO) begin
        spi_miso <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (do_arr_wr) begin
        mem_addr <= adr_q[10:0];
        mem_wdata <= wdata_q;
        mem_we <= 1'b1;
      end
    end
  end

  // Status bits and self-timed write cycle
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      busy_cnt_q <= 10'h000;
      busy_is_sr_q <= 1'b0;
      // Delivery state; no true non-volatile cell exists in this logic
      swd_q <= `NV_SWD_RST;
      bp_q <= `NV_BP_RST;
      swd_pend_q <= `NV_SWD_RST;
      bp_pend_q <= `NV_BP_RST;
    end else begin
      if (busy_q) begin
        if (busy_cnt_q == 10'h000) begin
          busy_q <= 1'b0;
          wel_q <= 1'b0;
          if (busy_is_sr_q) begin
            // New protection takes effect only when the cycle ends
            swd_q <= swd_pend_q;
            bp_q <= bp_pend_q;
          end
        end else begin
          busy_cnt_q <= busy_cnt_q - 10'h001;
        end
      end else if (do_set_we) begin
        wel_q <= 1'b1;
      end else if (do_clr_we) begin
        wel_q <= 1'b0;
      end else if (do_stat_wr || do_arr_wr) begin
        busy_q <= 1'b1;
        busy_cnt_q <= WR_CYC - 10'h001;
        busy_is_sr_q <= do_stat_wr;
        swd_pend_q <= wdata_q[`SR_SWD];
        bp_pend_q <= {wdata_q[`SR_BP_HI], wdata_q[`SR_BP_LO]};
      end
    end
  end

endmodule

// ==== testbench/prot_chk.sv ====
// Port assertions for the EEPROM command and protection block.
// Assumes the bench runs a short write time of ten ref_clk cycles.
module prot_chk #(
  parameter WRITE_TIME_NS = 80
) (
  input wire ref_clk,
  input wire rst_n,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  input wire spi_hold_n,
  input wire spi_wp_n,
  input wire spi_miso,
  input wire spi_miso_oe,
  input wire [10:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_we,
  input wire [7:0] mem_rdata,
  input wire active_pwr,
  input wire standby_pwr,
  input wire hold_state,
  input wire [7:0] status_protect_register
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [2:0] wp_lo_q;
  wire [7:0] sr = status_protect_register;
  wire prot = sr[3] & sr[2] | sr[3] & mem_addr[10] | sr[2] & (mem_addr[10:9] == 2'h3);
  // Counts protect pin low time so its synchroniser delay is covered
  always @(posedge ref_clk) begin
    if (!rst_n || spi_wp_n) begin
      wp_lo_q <= 3'h0;
    end else if (wp_lo_q != 3'h7) begin
      wp_lo_q <= wp_lo_q + 3'h1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  pwr_excl_a: assert property (active_pwr |-> !standby_pwr)
    else $error("active and standby both high");
  act_follow_a: assert property (active_pwr == !$past(spi_cs_n, 2))
    else $error("active power does not follow select");
  standby_idle_a: assert property (standby_pwr |-> !sr[0])
    else $error("standby during a write cycle");
  hold_float_a: assert property (hold_state |-> !spi_miso_oe)
    else $error("output driven while paused");
  desel_hold_a: assert property (!active_pwr [*2] |-> !hold_state)
    else $error("pause kept while deselected");
  write_gate_a: assert property (mem_we |-> $past(sr[1]) && !prot)
    else $error("array write without latch or in protected area");
  write_start_a: assert property (mem_we |=> !mem_we && sr[0])
    else $error("write pulse not followed by busy");
  busy_len_a: assert property ($rose(sr[0]) |-> sr[0][*8] ##1 sr[0][*2] ##[1:2] !sr[0])
    else $error("busy length wrong");
  wel_clear_a: assert property ($fell(sr[0]) |-> ##[0:1] !sr[1])
    else $error("latch not cleared at write completion");
  hpm_freeze_a: assert property (wp_lo_q == 3'h7 && $past(sr[7]) |-> $stable({sr[7], sr[3:2]}))
    else $error("protect bits changed in hardware protected mode");
  wel_desel_a: assert property ($rose(sr[1]) |-> !active_pwr)
    else $error("latch set before deselect");
endmodule

bind eeprom_cmd_protect prot_chk #(.WRITE_TIME_NS(WRITE_TIME_NS)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
  .active_pwr(active_pwr), .standby_pwr(standby_pwr), .hold_state(hold_state),
  .status_protect_register(status_protect_register)
);

// ==== testbench/spi_host_model.sv ====
// Serial bus master model, mode 0, 64 ns serial clock.
// Assumes all changes land on ref_clk falling edges.
module spi_host_model (
  input wire logic ref_clk,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic spi_hold_n,
  output logic spi_wp_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    spi_hold_n = 1'b1;
    spi_wp_n = 1'b1;
  end
  task automatic set_wp(input logic v);
    @(negedge ref_clk);
    spi_wp_n = v;
  endtask
  // Pause before bit hb; ab deselects during the pause
  task automatic xfer(input logic [39:0] d, input int n, input int hb, input bit ab,
                      output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    for (i = 0; i <= n; i++) begin
      if (i == hb) begin
        // pause only while selected, clock low
        #16 spi_hold_n = 1'b0;
        #16 spi_sclk = 1'b1;
        spi_mosi = ~spi_mosi;
        #32 spi_sclk = 1'b0;
        if (ab) begin
          spi_cs_n = 1'b1;
          #64 spi_hold_n = 1'b1;
          return;
        end
        #32 spi_hold_n = 1'b1;
      end
      if (i == n) break;
      spi_mosi = d[n-1-i];
      #32 spi_sclk = 1'b1;
      #32 rx = {rx[6:0], spi_miso};
      spi_sclk = 1'b0;
    end
    // deselect between last rise and the next
    #16 spi_cs_n = 1'b1;
    // Released data line is not left at its last value
    spi_mosi = ~spi_mosi;
    #64;
  endtask
endmodule

// ==== testbench/spi_eeprom_cmd_protect_bench.sv ====
// Self-checking bench for the EEPROM command and protection block.
// Assumes the array is modelled here as data = low address bits xor 5Ah.
module spi_eeprom_cmd_protect_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_hold_n, spi_wp_n, spi_miso, spi_miso_oe;
  wire mem_we, active_pwr, standby_pwr, hold_state;
  wire [10:0] mem_addr;
  wire [7:0] mem_wdata, status_protect_register;
  // Undriven line shows the inverse, so a read outside the drive window fails
  wire miso_bus = spi_miso_oe ? spi_miso : ~spi_miso;
  int fails = 0;
  int checked = 0;
  int we_cnt = 0;
  int j, n0;
  logic [31:0] seed = 32'h770205AC;
  logic [7:0] rx;
  logic [10:0] we_a, a;
  logic [7:0] we_d;
  logic [1:0] bp;
  logic ok;
  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) mem_rdata <= mem_addr[7:0] ^ 8'h5A;
  always @(posedge ref_clk) begin
    if (mem_we === 1'b1) begin
      we_cnt <= we_cnt + 1;
      we_a <= mem_addr;
      we_d <= mem_wdata;
    end
  end
  // Short write time keeps the run brief
  eeprom_cmd_protect #(.WRITE_TIME_NS(80)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
    .active_pwr(active_pwr), .standby_pwr(standby_pwr), .hold_state(hold_state),
    .status_protect_register(status_protect_register));
  spi_host_model host (.ref_clk(ref_clk), .spi_miso(miso_bus), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_hold_n(spi_hold_n),
    .spi_wp_n(spi_wp_n));
  task test_done;
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function logic prot(input logic [1:0] p, input logic [10:0] ad);
    return p == 2'h3 || (p == 2'h2 && ad >= 11'h400) || (p == 2'h1 && ad >= 11'h600);
  endfunction
  task op(input logic [39:0] d, input int n);
    host.xfer(d, n, -1, 1'b0, rx);
  endtask
  task status_read_cmd(input logic [7:0] e);
    op(16'h0500, 16);
    chk(rx, e);
  endtask
  task wait_idle(input logic b);
    int k;
    chk({standby_pwr, status_protect_register[0]}, {~b, b});
    for (k = 0; k < 400; k++) begin
      @(negedge ref_clk);
      if (status_protect_register[0] === 1'b0) return;
    end
    fails++;
    test_done();
  endtask
  task status_write_cmd(input logic [7:0] v, input logic b);
    op(8'h06, 8);
    op({8'h01, v}, 16);
    wait_idle(b);
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    status_read_cmd(8'h00);
    op({8'hA5, 8'h06}, 16);
    status_read_cmd(8'h00);
    op({8'h06, 1'b0}, 9);
    status_read_cmd(8'h00);
    op(8'h06, 8);
    status_read_cmd(8'h02);
    op(8'h04, 8);
    status_read_cmd(8'h00);
    op({8'h01, 8'h8C}, 16);
    status_read_cmd(8'h00);
    host.xfer(8'h06, 8, 3, 1'b0, rx);
    status_read_cmd(8'h02);
    op(8'h04, 8);
    host.xfer(8'h06, 8, 8, 1'b1, rx);
    status_read_cmd(8'h00);
    status_write_cmd(8'h8C, 1'b1);
    status_read_cmd(8'h8C);
    host.set_wp(1'b0);
    status_write_cmd(8'h00, 1'b0);
    status_read_cmd(8'h8E);
    host.set_wp(1'b1);
    for (j = 0; j < 8; j++) begin
      seed = xs(seed);
      bp = j[1:0];
      a = (j == 5) ? 11'h5FF : (j == 6) ? 11'h400 : seed[10:0];
      status_write_cmd({4'h0, bp, 2'h0}, 1'b1);
      n0 = we_cnt;
      op(8'h06, 8);
      op({8'h02, 5'h00, a, seed[23:16]}, 32);
      ok = !prot(bp, a);
      chk(we_cnt - n0, ok);
      if (ok) chk({we_a, we_d}, {a, seed[23:16]});
      wait_idle(ok);
      status_read_cmd({4'h0, bp, !ok, 1'b0});
    end
    status_write_cmd(8'h00, 1'b1);
    n0 = we_cnt;
    op(8'h06, 8);
    op({8'h02, 5'h00, a, seed[23:17]}, 31);
    op(8'h04, 8);
    op({8'h02, 5'h00, a, seed[23:16]}, 32);
    chk(we_cnt - n0, 0);
    op({8'h03, 5'h00, a, 8'h00}, 32);
    chk(rx, a[7:0] ^ 8'h5A);
    test_done();
  end
endmodule
